// >>> src/tx_char_control_builtin_self_test.sv
// four-lane transmit character control with self-test generators
// assumes all lane inputs synchronous to sys_clk; configuration
// over an ahb-lite slave with zero wait states
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// How it works
// - mode 4 joins select with control bits
// - modes 4/7 map data, fill, special, sync
// - mid clock source: select sampled on lane A
// - mode 4 sync starts on select and bit0
// - mode 5 unbonded map ignores select
// - mode 5 unbonded sync needs both bits high
// - dual bonding pairs lanes A/B, C/D
// - pair maps own bit1 with first bit0
// - second lane bit0 syncs whole pair
// - quad: A and B bit0 govern all
// - low enable bit starts lane self-test
// - self-test register yields 511 characters
// - word sync precedes each pass when common
// - latch captures enables on falling edge
// - device reset disables all self-test
// - self-test lane ignores parallel inputs
// - characters leave least significant bit first
// - atomic sync sends sixteen, ignores inputs
// - modes 7/8 sync continues only on 00
// - quad: lane B bit0 syncs all four
// - odd enable bits drive transmit lanes
module tx_char_control_builtin_self_test
  import txcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic special_code_select,
  input wire logic lane_a_tx_clock,
  input wire logic [7:0] lane_char_control,
  input wire logic [31:0] lane_char_data,
  input wire logic [7:0] lane_enable_bus,
  input wire logic selftest_latch_enable,
  input wire logic device_reset_n,
  output logic [7:0] lane_kind,
  output logic [31:0] lane_byte,
  output logic [3:0] lane_serial,
  output logic [3:0] lane_sync_active,
  output logic [3:0] lane_selftest_active
);
  logic [CFG_BITS-1:0] config_reg;
  logic [3:0] tx_mode_select;
  logic [1:0] rx_bonding_mode;
  logic [1:0] tx_clock_source_sel;
  logic [1:0] rx_clock_source_sel;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [3:0] char_cnt;
  logic char_tick;
  logic lane_a_clk_prev;
  logic special_code_select_lane_a;
  logic special_code_select_eff;
  logic [7:0] selftest_latch;
  logic [3:0] test_en;
  logic [3:0] start_sync;
  logic [7:0] dec_kind;
  logic [3:0] hold_ok;
  logic interruptible;
  logic sync_first;
  logic [1:0] lane_kind_w [NUM_LANES];
  logic [7:0] lane_byte_w [NUM_LANES];
  logic [3:0] serial_w;
  logic [3:0] sync_w;

  assign tx_mode_select = config_reg[CFG_MODE_LSB +: 4];
  assign rx_bonding_mode = config_reg[CFG_BOND_LSB +: 2];
  assign tx_clock_source_sel = config_reg[CFG_TXCK_LSB +: 2];
  assign rx_clock_source_sel = config_reg[CFG_RXCK_LSB +: 2];

  // ******************************************************
  // ahb-lite slave
  // ******************************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      wr_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        // read data ready in the data phase; unmapped reads zero
        unique case (haddr[7:0])
          ADDR_CONFIG: hrdata <= {{(32-CFG_BITS){1'b0}}, config_reg};
          ADDR_STATUS: hrdata <= {16'h0000, lane_selftest_active,
            lane_sync_active, selftest_latch};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      config_reg <= CONFIG_RESET[CFG_BITS-1:0];
    end else if (wr_pend && wr_addr == ADDR_CONFIG) begin
      config_reg <= hwdata[CFG_BITS-1:0];
    end
  end

  // ******************************************************
  // character period and select capture
  // ******************************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      char_cnt <= 4'h0;
      char_tick <= 1'b0;
    end else begin
      char_tick <= char_cnt == CHAR_LAST;
      char_cnt <= (char_cnt == CHAR_LAST) ? 4'h0 : char_cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lane_a_clk_prev <= 1'b0;
      special_code_select_lane_a <= 1'b0;
    end else begin
      lane_a_clk_prev <= lane_a_tx_clock;
      if (lane_a_tx_clock && !lane_a_clk_prev) begin
        special_code_select_lane_a <= special_code_select;
      end
    end
  end

  // with the mid clock source, lane A's captured level is handed to every lane on the tick
  assign special_code_select_eff = (tx_clock_source_sel == LVL_MID) ?
    special_code_select_lane_a : special_code_select;

  // ******************************************************
  // self-test enable latch
  // ******************************************************
  always_ff @(posedge sys_clk) begin
    if (!device_reset_n) begin
      selftest_latch <= LATCH_PRESET;
    end else if (selftest_latch_enable) begin
      // open while high, holds from the falling edge on
      selftest_latch <= lane_enable_bus;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      test_en[i] = !selftest_latch[2*i+1];
    end
  end

  assign sync_first = rx_clock_source_sel != LVL_MID
    && tx_mode_select >= MODE_3;
  assign interruptible = tx_mode_select >= MODE_6;

  // ******************************************************
  // control decode
  // ******************************************************
  always_comb begin
    logic [1:0] c [NUM_LANES];
    logic b0;
    for (int i = 0; i < NUM_LANES; i++) begin
      c[i] = lane_char_control[2*i +: 2];
    end
    b0 = 1'b0;
    start_sync = 4'h0;
    dec_kind = {4{KIND_DATA}};
    for (int i = 0; i < NUM_LANES; i++) begin
      hold_ok[i] = c[i] == 2'b00;
      unique case (tx_mode_select)
        MODE_3, MODE_6: begin
          if (c[i] == 2'b01) begin
            dec_kind[2*i +: 2] = special_code_select_eff ? KIND_SPECIAL : KIND_FILL;
          end
          start_sync[i] = c[i] == 2'b11;
        end
        MODE_4, MODE_7: begin
          if (c[i][0] && !special_code_select_eff) begin
            dec_kind[2*i +: 2] = c[i][1] ? KIND_SPECIAL : KIND_FILL;
          end
          start_sync[i] = special_code_select_eff && c[i][0];
        end
        MODE_5, MODE_8: begin
          if (rx_bonding_mode == LVL_LOW) begin
            dec_kind[2*i +: 2] = c[i];
            start_sync[i] = c[i] == 2'b11;
          end else if (rx_bonding_mode == LVL_MID) begin
            // pair lead bit0 is lane A or C, force bit0 lane B or D
            b0 = c[i & 2][0];
            if (c[i | 1][0]) begin
              start_sync[i] = 1'b1;
            end else begin
              dec_kind[2*i +: 2] = {c[i][1], b0};
              start_sync[i] = c[i][1] && b0;
            end
          end else begin
            b0 = c[0][0];
            if (c[1][0]) begin
              start_sync[i] = 1'b1;
            end else begin
              dec_kind[2*i +: 2] = {c[i][1], b0};
              start_sync[i] = c[i][1] && b0;
            end
          end
        end
        default: begin
          // bypass and test modes pass data through unchanged
          start_sync[i] = 1'b0;
        end
      endcase
    end
  end

  // ******************************************************
  // lanes
  // ******************************************************
  for (genvar g = 0; g < NUM_LANES; g++) begin : gen_lane
    tx_lane_unit u_lane (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .char_tick(char_tick),
      .start_sync(start_sync[g]),
      .interruptible(interruptible),
      .hold_ok(hold_ok[g]),
      .selftest_en(test_en[g]),
      .sync_first(sync_first),
      .in_kind(dec_kind[2*g +: 2]),
      .in_byte(lane_char_data[8*g +: 8]),
      .lane_kind(lane_kind_w[g]),
      .lane_byte(lane_byte_w[g]),
      .lane_serial(serial_w[g]),
      .sync_active(sync_w[g])
    );
  end

  // ******************************************************
  // output registers
  // ******************************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lane_kind <= {4{KIND_FILL}};
      lane_byte <= {4{FILL_BYTE}};
      lane_serial <= 4'h0;
      lane_sync_active <= 4'h0;
      lane_selftest_active <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_LANES; i++) begin
        lane_kind[2*i +: 2] <= lane_kind_w[i];
        lane_byte[8*i +: 8] <= lane_byte_w[i];
      end
      lane_serial <= serial_w;
      lane_sync_active <= sync_w;
      lane_selftest_active <= test_en;
    end
  end
endmodule

// >>> src/tx_lane_unit.sv
// one transmit lane: word sync sequencer, test pattern register
// and ten-bit shifter; assumes a one-cycle char_tick every
// character period from the top
`timescale 1ns/1ps
module tx_lane_unit
  import txcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic char_tick,
  input wire logic start_sync,
  input wire logic interruptible,
  input wire logic hold_ok,
  input wire logic selftest_en,
  input wire logic sync_first,
  input wire logic [1:0] in_kind,
  input wire logic [7:0] in_byte,
  output logic [1:0] lane_kind,
  output logic [7:0] lane_byte,
  output logic lane_serial,
  output logic sync_active
);
  logic [3:0] sync_cnt;
  logic [8:0] pat;
  logic pre_done;
  logic [CHAR_BITS-1:0] shreg;
  logic [1:0] next_kind;
  logic [7:0] next_byte;
  logic [3:0] next_cnt;
  logic next_pre;
  logic advance;

  // ******************************************************
  // next character selection
  // ******************************************************
  always_comb begin
    next_kind = in_kind;
    // a fill character always carries the comma byte, not host data
    next_byte = (in_kind == KIND_FILL) ? FILL_BYTE : in_byte;
    next_cnt = 4'h0;
    next_pre = 1'b0;
    advance = 1'b0;
    if (selftest_en) begin
      // parallel inputs are not looked at here at all
      if (sync_cnt != 4'h0) begin
        next_kind = KIND_FILL;
        next_byte = FILL_BYTE;
        next_cnt = sync_cnt - 4'h1;
        next_pre = 1'b1;
      end else if (sync_first && pat == PAT_SEED && !pre_done) begin
        next_kind = KIND_FILL;
        next_byte = FILL_BYTE;
        next_cnt = SYNC_LEN_M1;
        next_pre = 1'b1;
      end else begin
        next_kind = pat[8] ? KIND_SPECIAL : KIND_PATTERN;
        next_byte = pat[7:0];
        advance = 1'b1;
      end
    end else if (sync_cnt != 4'h0) begin
      if (interruptible && !hold_ok && start_sync) begin
        // a fresh start condition ends the run and begins a new one
        next_kind = KIND_FILL;
        next_byte = FILL_BYTE;
        next_cnt = SYNC_LEN_M1;
      end else if (interruptible && !hold_ok) begin
        next_cnt = 4'h0;
      end else begin
        // atomic run ignores the input registers
        next_kind = KIND_FILL;
        next_byte = FILL_BYTE;
        next_cnt = sync_cnt - 4'h1;
      end
    end else if (start_sync) begin
      next_kind = KIND_FILL;
      next_byte = FILL_BYTE;
      next_cnt = SYNC_LEN_M1;
    end
  end

  // ******************************************************
  // sequencer and pattern state
  // ******************************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sync_cnt <= 4'h0;
      pre_done <= 1'b0;
    end else if (char_tick) begin
      sync_cnt <= next_cnt;
      pre_done <= next_pre;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || !selftest_en) begin
      pat <= PAT_SEED;
    end else if (char_tick && advance) begin
      // 9-bit maximal sequence, period 511
      pat <= {pat[7:0], pat[8] ^ pat[PAT_TAP]};
    end
  end

  // ******************************************************
  // character output and shifter
  // ******************************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lane_kind <= KIND_FILL;
      lane_byte <= FILL_BYTE;
      shreg <= {KIND_FILL, FILL_BYTE};
      lane_serial <= 1'b0;
      sync_active <= 1'b0;
    end else begin
      lane_serial <= shreg[0];
      if (char_tick) begin
        lane_kind <= next_kind;
        lane_byte <= next_byte;
        shreg <= {next_kind, next_byte};
        sync_active <= next_cnt != 4'h0 || next_kind == KIND_FILL
          && next_byte == FILL_BYTE && sync_cnt != 4'h0;
      end else begin
        shreg <= {1'b0, shreg[CHAR_BITS-1:1]};
      end
    end
  end
endmodule

// >>> src/txcc_pkg.sv
// constants, register map and character codes for the transmit
// character-control block; shared by the top and the lane unit
package txcc_pkg;
  // ******************************************************
  // character timing
  // ******************************************************
  localparam int CHAR_BITS = 10;
  localparam logic [3:0] CHAR_LAST = 4'h9;
  localparam logic [3:0] SYNC_LEN_M1 = 4'hf;
  localparam int NUM_LANES = 4;

  // ******************************************************
  // character kinds carried in the two top bits of a character
  // ******************************************************
  typedef enum logic [1:0] {
    KIND_DATA = 2'b00,
    KIND_FILL = 2'b01,
    KIND_SPECIAL = 2'b10,
    KIND_PATTERN = 2'b11
  } char_kind_e;
  localparam logic [7:0] FILL_BYTE = 8'hbc;

  // ******************************************************
  // three-level selects as two-bit codes
  // ******************************************************
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // ******************************************************
  // transmit mode numbers
  // ******************************************************
  localparam logic [3:0] MODE_3 = 4'h3;
  localparam logic [3:0] MODE_4 = 4'h4;
  localparam logic [3:0] MODE_5 = 4'h5;
  localparam logic [3:0] MODE_6 = 4'h6;
  localparam logic [3:0] MODE_7 = 4'h7;
  localparam logic [3:0] MODE_8 = 4'h8;

  // ******************************************************
  // pattern generator
  // ******************************************************
  localparam logic [8:0] PAT_SEED = 9'h1ff;
  localparam int PAT_TAP = 4;

  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0005;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_BOND_LSB = 4;
  localparam int CFG_TXCK_LSB = 6;
  localparam int CFG_RXCK_LSB = 8;
  localparam int CFG_BITS = 10;
  localparam int ST_LATCH_LSB = 0;
  localparam int ST_SYNC_LSB = 8;
  localparam int ST_TEST_LSB = 12;
  localparam logic [7:0] LATCH_PRESET = 8'hff;
endpackage

// >>> verif/lane_host_model.sv
// host framing side: drives the parallel character lanes
// assumes bench requests in the same clock domain
`timescale 1ns/1ps
module lane_host_model (
  input wire logic sys_clk,
  input wire logic req_sel,
  input wire logic [7:0] req_ctl,
  input wire logic [31:0] req_data,
  output logic special_code_select = 1'b0,
  output logic [7:0] lane_char_control = 8'h00,
  output logic [31:0] lane_char_data = 32'h0
);
  // select follows every request one clock later, like the lanes
  always_ff @(posedge sys_clk) begin
    special_code_select <= req_sel;
    lane_char_control <= req_ctl;
    lane_char_data <= req_data;
  end
endmodule

// >>> verif/tx_char_control_builtin_self_test_tb_top.sv
// self-checking bench for the transmit character-control block
// assumes a zero-wait ahb slave and the host model on the lanes
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin comparisons++; \
  if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tx_char_control_builtin_self_test_tb_top
  import txcc_pkg::*;
;
  logic sys_clk = 0, resetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, lane_char_data;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic hreadyout, hresp, special_code_select, req_sel = 0;
  logic lane_a_tx_clock = 0, selftest_latch_enable = 0;
  logic device_reset_n = 0;
  logic [7:0] lane_enable_bus = 8'hff, lane_char_control, lane_kind;
  logic [7:0] req_ctl = 0;
  logic [31:0] req_data = 0, lane_byte;
  logic [3:0] lane_serial, lane_sync_active, lane_selftest_active;
  int n_fail = 0, comparisons = 0, seed = 20;
  int modes[4] = '{4, 5, 7, 8};
  assign hready = hreadyout;

  tx_char_control_builtin_self_test DUT (.sys_clk, .resetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .special_code_select, .lane_a_tx_clock,
    .lane_char_control, .lane_char_data, .lane_enable_bus,
    .selftest_latch_enable, .device_reset_n, .lane_kind, .lane_byte,
    .lane_serial, .lane_sync_active, .lane_selftest_active);
  lane_host_model host (.sys_clk, .req_sel, .req_ctl, .req_data,
    .special_code_select, .lane_char_control, .lane_char_data);

  initial forever #20 sys_clk = ~sys_clk;

  // ****************************************
  // bus cycles and the reference model
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic finish_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (!hreadyout && ++n < 50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (!hreadyout && ++n < 100);
    rd = hrdata;
    if (n >= 50) n_fail++;
  endtask

  // 4 stands for a word sync, which shows as fill characters
  function automatic int model(int md, int bd, logic sel,
                               logic [7:0] c, int ln);
    logic b1, b0;
    b1 = c[2*ln+1];
    b0 = c[2*ln];
    if (md == 4 || md == 7) begin
      if (!b0) return 0;
      if (sel) return 4;
      return b1 ? 2 : 1;
    end
    if (bd == 1) begin
      if (c[(ln/2)*4+2]) return 4;
      b0 = c[(ln/2)*4];
    end else if (bd == 2) begin
      if (c[2]) return 4;
      b0 = c[0];
    end
    return b1 ? (b0 ? 4 : 2) : (b0 ? 1 : 0);
  endfunction

  task automatic la(input logic [7:0] c, input int w,
                    input logic [1:0] k, input logic s);
    req_ctl <= c;
    wt(w);
    `CHECK("kind a", k, lane_kind[1:0])
    `CHECK("sync a", s, lane_sync_active[0])
  endtask

  task automatic pulse_a;
    lane_a_tx_clock <= 1;
    wt(2);
    lane_a_tx_clock <= 0;
  endtask

  initial begin
    wt(20000);
    n_fail++;
    finish_test;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] rd, d;
    logic [19:0] sb;
    logic [9:0] p;
    logic ok, m;
    logic [7:0] c;
    int r, md, bd, e;
    wt(10);
    resetn <= 1;
    device_reset_n <= 1;
    wt(1);
    ahb(0, 32'(ADDR_CONFIG), 0, rd);
    `CHECK("cfg reset", CONFIG_RESET, rd)
    ahb(1, 32'(ADDR_CONFIG), 32'h296, rd);
    ahb(0, 32'(ADDR_CONFIG), 0, rd);
    `CHECK("cfg back", 32'h296, rd)
    ahb(0, 32'h8, 0, rd);
    `CHECK("unmapped", 32'h0, rd)
    ahb(1, 32'(ADDR_CONFIG), 32'h5, rd);
    la(8'h03, 40, KIND_FILL, 1);
    la(8'h00, 40, KIND_FILL, 1);
    la(8'h00, 200, KIND_DATA, 0);
    ahb(1, 32'(ADDR_CONFIG), 32'h8, rd);
    la(8'h03, 40, KIND_FILL, 1);
    la(8'h02, 40, KIND_SPECIAL, 0);
    la(8'h00, 200, KIND_DATA, 0);
    ahb(1, 32'(ADDR_CONFIG), 32'h44, rd);
    pulse_a();
    la(8'h01, 40, KIND_FILL, 0);
    req_sel <= 1;
    la(8'h01, 40, KIND_FILL, 0);
    pulse_a();
    la(8'h01, 40, KIND_FILL, 1);
    req_sel <= 0;
    pulse_a();
    la(8'h00, 200, KIND_DATA, 0);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      md = modes[r[1:0]];
      bd = r[3:2] % 3;
      c = 8'($random(seed));
      d = $random(seed);
      ahb(1, 32'(ADDR_CONFIG), 32'(md) | 32'(bd) << CFG_BOND_LSB, rd);
      req_sel <= r[4];
      req_ctl <= c;
      req_data <= d;
      wt(40);
      for (int k = 0; k < 4; k++) begin
        e = model(md, bd, r[4], c, k);
        `CHECK("kind", (e == 4) ? 2'h1 : 2'(e), lane_kind[2*k+:2])
        if (md < 6) `CHECK("sync", e == 4, lane_sync_active[k])
        if (e < 2) `CHECK("byte", e ? FILL_BYTE : d[8*k+:8], lane_byte[8*k+:8])
      end
      req_ctl <= 0;
      req_sel <= 0;
      wt(200);
    end
    ahb(1, 32'(ADDR_CONFIG), 32'h105, rd);
    req_data <= 32'h2d;
    p = 10'h02d;
    wt(40);
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      #1 sb[i] = lane_serial[0];
    end
    ok = 0;
    for (int k = 0; k < 10; k++) begin
      m = 1;
      for (int i = 0; i < 20; i++) if (sb[i] !== p[(i+k)%10]) m = 0;
      ok |= m;
    end
    `CHECK("serial order", 1'b1, ok)
    selftest_latch_enable <= 1;
    lane_enable_bus <= 8'hfd;
    wt(5);
    `CHECK("test on", 4'h1, lane_selftest_active)
    selftest_latch_enable <= 0;
    wt(1);
    lane_enable_bus <= 8'hff;
    wt(60);
    `CHECK("test held", 4'h1, lane_selftest_active)
    `CHECK("test kind", 1'b0, lane_kind[1:0] === KIND_DATA)
    ahb(0, 32'(ADDR_STATUS), 0, rd);
    `CHECK("latch", 8'hfd, rd[7:0])
    device_reset_n <= 0;
    wt(3);
    device_reset_n <= 1;
    wt(1);
    `CHECK("test off", 4'h0, lane_selftest_active)
    finish_test;
  end
endmodule

bind tx_char_control_builtin_self_test txcc_properties props (.sys_clk, .resetn,
  .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .lane_enable_bus, .selftest_latch_enable, .device_reset_n,
  .lane_kind, .lane_byte, .lane_sync_active, .lane_selftest_active);

// >>> verif/txcc_properties.sv
// port assertions for the character-control block
// assumes a bind from the bench top; one clock, sync reset
`timescale 1ns/1ps
module txcc_properties
  import txcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [7:0] lane_enable_bus,
  input wire logic selftest_latch_enable,
  input wire logic device_reset_n,
  input wire logic [7:0] lane_kind,
  input wire logic [31:0] lane_byte,
  input wire logic [3:0] lane_sync_active,
  input wire logic [3:0] lane_selftest_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [5:0] st_cnt;
  logic rd_take;
  assign rd_take = hsel && htrans[1] && !hwrite && hready;
  // saturates, so long self-test runs never wrap
  always_ff @(posedge sys_clk) begin
    if (!resetn || !lane_selftest_active[0]) st_cnt <= 6'h0;
    else if (st_cnt != 6'h3f) st_cnt <= st_cnt + 6'h1;
  end
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  chk_read_stands: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved");
  chk_char_stands: assert property
    (!$stable(lane_kind) |=> $stable(lane_kind) [*8])
    else $error("character too short");
  chk_fill_byte: assert property
    (lane_kind[1:0] == KIND_FILL |-> lane_byte[7:0] == FILL_BYTE)
    else $error("fill byte wrong");
  chk_reset_latch: assert property
    (!device_reset_n [*3] |-> lane_selftest_active == 4'h0)
    else $error("self-test survives reset");
  chk_latch_open: assert property
    ((selftest_latch_enable && device_reset_n &&
      $stable(lane_enable_bus)) [*3] |-> lane_selftest_active ==
      ~{lane_enable_bus[7], lane_enable_bus[5],
        lane_enable_bus[3], lane_enable_bus[1]})
    else $error("open latch mismatch");
  chk_latch_hold: assert property
    ((!selftest_latch_enable && device_reset_n) [*3] |=>
      $stable(lane_selftest_active))
    else $error("closed latch moved");
  chk_test_kind: assert property
    (st_cnt >= 6'h1e |-> lane_kind[1:0] != KIND_DATA)
    else $error("data during self-test");
  cover property ($rose(lane_sync_active[0]));
  cover property ($rose(lane_selftest_active[0]));
  cover property (rd_take);
endmodule
